// ### smc_consts.svh
// Purpose: constants for the capability id low-field register block
// Assumes: included by the block module and the bench
// Notes: offsets are byte addresses on the register bus
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ============================================================
// register map
`define SMC_ADR_W 8
`define SMC_CAPID0_OFS 8'h00
`define SMC_SCFG1_OFS 8'h04
`define SMC_WORD_LSB 2

// ============================================================
// build configuration
`define SMC_IF_ACE_LITE 1'b0
`define SMC_BCAST_AXI 1'b0
`define SMC_BCAST_ACE 1'b1
`define SMC_SEC_EXT 1'b1
`define SMC_SID_BITS 4'h8
`define SMC_NUM_GROUPS 8'h10
`define SMC_ALLOC_RESET 8'h10

// ============================================================
// fields of secure_config_one
`define SMC_ALLOC_LSB 0
`define SMC_ALLOC_MSB 7
`define SMC_ALLOC_SEL 0

`define SMC_ZERO32 32'h0000_0000
`define SMC_ZERO16 16'h0000

`endif

// ### smc_pkg.sv
// Purpose: types for the capability id low-field register block
// Assumes: smc_consts.svh provides the numeric constants
// Notes: capability_id_zero layout is held as a packed struct
`default_nettype none
package smc_pkg;

  // ============================================================
  // capability_id_zero layout
  typedef struct packed {
    logic [15:0] upper;
    logic coherent_walk;
    logic broadcast_tlb_maint_support;
    logic [3:0] stream_id_bit_count;
    logic rsvd8;
    logic [7:0] stream_group_count;
  } smc_capid0_t;

  // ============================================================
  // bus request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } smc_wb_req_t;

endpackage
`default_nettype wire

// ### smc_capid.sv
// Purpose: capability id low fields with a wishbone register slave
// Assumes: classic wishbone, one clock, synchronous active-high reset
// Notes: SECURE_I qualifies each access as secure or non-secure
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "smc_consts.svh"

// Operation
// - Bit 14 follows the coherent-walk tie-off input directly.
// - Bit 13 reads 0 for an AXI3/AXI4 build and 1 for an ACE-Lite build.
// - Bits 12 to 9 give the configured stream id width, range 0 to 15.
// - Bits 7 to 0 give the configured number of stream mapping groups.
// - With security extensions a non-secure read of the group count gives the non-secure alloc.
// - Non-secure reads see counts without the secure-reserved groups.
module smc_capid (
  input wire logic MCLK_I, // 200 MHz clock
  input wire logic RST_I, // synchronous reset
  input wire smc_pkg::smc_wb_req_t WB_I, // bus request group
  input wire logic SECURE_I, // access is secure
  input wire logic CFG_COH_WALK_I, // coherent walk tie-off
  output logic [31:0] DAT_O, // read data
  output logic ACK_O // bus acknowledge
);
  import smc_pkg::*;

  // ============================================================
  // decode
  logic req;
  logic hit_id;
  logic hit_scfg;
  logic [7:0] alloc_q;
  logic [7:0] alloc_d;
  logic ack_q;
  logic [31:0] dat_q;
  logic rd_take;
  logic wr_take;
  smc_capid0_t id_view;

  // word compare, byte lanes ignored
  function automatic logic adr_is(input logic [7:0] a, input logic [7:0] o);
    adr_is = (a[`SMC_ADR_W-1:`SMC_WORD_LSB] ==
              o[`SMC_ADR_W-1:`SMC_WORD_LSB]);
  endfunction

  // counts beyond the implemented groups are cut back
  function automatic logic [7:0] clamp_alloc(input logic [7:0] v);
    if (v > `SMC_NUM_GROUPS) begin
      clamp_alloc = `SMC_NUM_GROUPS;
    end else begin
      clamp_alloc = v;
    end
  endfunction

  assign req = WB_I.cyc & WB_I.stb & ~ack_q;
  assign hit_id = adr_is(WB_I.adr, `SMC_CAPID0_OFS);
  assign hit_scfg = adr_is(WB_I.adr, `SMC_SCFG1_OFS);
  assign rd_take = req & ~WB_I.we;
  assign wr_take = req & WB_I.we;

  // ============================================================
  // secure_config_one alloc field, secure writes only, clamped
  always_comb begin
    alloc_d = alloc_q;
    if (req && WB_I.we && hit_scfg && SECURE_I &&
        WB_I.sel[`SMC_ALLOC_SEL]) begin
      alloc_d = clamp_alloc(
        WB_I.dat[`SMC_ALLOC_MSB:`SMC_ALLOC_LSB]);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      alloc_q <= `SMC_ALLOC_RESET;
    end else begin
      alloc_q <= alloc_d;
    end
  end

  // ============================================================
  // capability_id_zero view for this access
  always_comb begin
    id_view = '0;
    id_view.upper = `SMC_ZERO16;
    id_view.coherent_walk = CFG_COH_WALK_I;
    id_view.broadcast_tlb_maint_support =
      `SMC_IF_ACE_LITE ? `SMC_BCAST_ACE : `SMC_BCAST_AXI;
    id_view.stream_id_bit_count = `SMC_SID_BITS;
    id_view.rsvd8 = 1'b0;
    id_view.stream_group_count = `SMC_NUM_GROUPS;
    if (`SMC_SEC_EXT && !SECURE_I) begin
      id_view.stream_group_count = alloc_q;
    end
  end

  // ============================================================
  // bus answer: ack one cycle after request, unmapped reads zero
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dat_q <= `SMC_ZERO32;
    end else if (rd_take) begin
      if (hit_id) begin
        dat_q <= id_view;
      end else if (hit_scfg && SECURE_I) begin
        dat_q <= {24'h00_0000, alloc_q};
      end else begin
        dat_q <= `SMC_ZERO32;
      end
    end
  end

  assign DAT_O = dat_q;
  assign ACK_O = ack_q;

  // ============================================================
  // checks
  sequence s_read_id;
    rd_take && hit_id;
  endsequence

  sequence s_read_scfg;
    rd_take && hit_scfg;
  endsequence

  sequence s_read_other;
    rd_take && !hit_id && !hit_scfg;
  endsequence

  sequence s_ns_alloc_write;
    wr_take && hit_scfg && !SECURE_I;
  endsequence

  sequence s_sec_alloc_write;
    wr_take && hit_scfg && SECURE_I && WB_I.sel[`SMC_ALLOC_SEL];
  endsequence

  sequence s_write_id;
    wr_take && hit_id;
  endsequence

  a_coh_walk_bit: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_id |=> DAT_O[14] == $past(CFG_COH_WALK_I))
    else $error("coherent walk bit wrong");

  a_bcast_bit: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_id |=> DAT_O[13] == `SMC_IF_ACE_LITE)
    else $error("broadcast tlb bit wrong");

  a_sid_width: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_id |=> DAT_O[12:9] == `SMC_SID_BITS)
    else $error("stream id width wrong");

  a_secure_count: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_id ##0 SECURE_I |=> DAT_O[7:0] == `SMC_NUM_GROUPS)
    else $error("secure group count wrong");

  a_ns_count: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_id ##0 !SECURE_I |=> DAT_O[7:0] == $past(alloc_q))
    else $error("non-secure group count wrong");

  a_alloc_write: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_sec_alloc_write |=> alloc_q ==
      clamp_alloc($past(WB_I.dat[`SMC_ALLOC_MSB:`SMC_ALLOC_LSB])))
    else $error("secure alloc write not applied");

  a_alloc_bound: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    alloc_q <= `SMC_NUM_GROUPS)
    else $error("alloc above implemented count");

  a_ns_no_write: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_ns_alloc_write |=> $stable(alloc_q))
    else $error("non-secure write changed alloc");

  a_scfg_hidden: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_scfg ##0 !SECURE_I |=> DAT_O == `SMC_ZERO32)
    else $error("non-secure read saw secure config");

  a_scfg_read: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_scfg ##0 SECURE_I |=> DAT_O[7:0] == $past(alloc_q))
    else $error("secure config readback wrong");

  a_rsvd_zero: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_id |=> DAT_O[8] == 1'b0 && DAT_O[31:15] == 17'h0_0000)
    else $error("reserved id bits not zero");

  a_id_wr_ignored: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_write_id |=> $stable(alloc_q) && $stable(DAT_O))
    else $error("write to id register had an effect");

  a_unmapped_zero: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    s_read_other |=> DAT_O == `SMC_ZERO32)
    else $error("unmapped read not zero");

  a_ack_next: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    req |=> ACK_O)
    else $error("request not acknowledged");

  a_ack_idle: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !req |=> !ACK_O)
    else $error("ack without request");

  a_ack_once: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");

  a_reset_state: assert property (
    @(posedge MCLK_I)
    $past(RST_I) && !RST_I |->
      !ACK_O && DAT_O == `SMC_ZERO32 && alloc_q == `SMC_ALLOC_RESET)
    else $error("state after reset wrong");

endmodule
`default_nettype wire

// ### tb_smc_capid.sv
// Purpose: self-checking bench for the capability id low fields
// Assumes: smc_consts.svh and smc_pkg are compiled first
// Notes: secure and non-secure views are read over classic wishbone
`timescale 1ns/100ps
`default_nettype none
`include "smc_consts.svh"
module tb_smc_capid;
  import smc_pkg::*;
  // ============================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  smc_wb_req_t req = '0;
  logic sec = 1'b1;
  logic coh = 1'b0;
  logic [3:0] bsel = 4'hF;
  logic [31:0] dat;
  logic ack;
  logic [31:0] rd;
  int n_fail = 0;
  int tests_run = 0;
  localparam logic BCAST =
    `SMC_IF_ACE_LITE ? `SMC_BCAST_ACE : `SMC_BCAST_AXI;

  smc_capid DUT (.MCLK_I(clk), .RST_I(rst), .WB_I(req), .SECURE_I(sec),
    .CFG_COH_WALK_I(coh), .DAT_O(dat), .ACK_O(ack));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ============================================================
  // shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; read data lands in rd at the acking edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic s);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: bsel, adr: a, dat: d};
    sec <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack});
    rd = dat;
    req <= '0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] idv(input logic c, input logic [7:0] g);
    return {17'h0, c, BCAST, `SMC_SID_BITS, 1'b0, g};
  endfunction

  // ============================================================
  // scenarios
  task automatic t_reset();
    @(posedge clk);
    chk("dat after reset", `SMC_ZERO32, dat);
    chk("ack after reset", 32'h0, {31'h0, ack});
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b0);
    chk("ns id reset", idv(coh, `SMC_ALLOC_RESET), rd);
  endtask

  task automatic t_fields();
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      coh <= c[0];
      wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b1);
      chk("walk bit", {31'h0, c[0]}, {31'h0, rd[14]});
      chk("bcast bit", {31'h0, BCAST}, {31'h0, rd[13]});
      chk("sid bits", {28'h0, `SMC_SID_BITS}, {28'h0, rd[12:9]});
      chk("groups", {24'h0, `SMC_NUM_GROUPS}, {24'h0, rd[7:0]});
      chk("id", idv(c[0], `SMC_NUM_GROUPS), rd);
    end
  endtask

  task automatic t_wr_ignored();
    wb(1'b1, `SMC_CAPID0_OFS, 32'hFFFF_FFFF, 1'b1);
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b1);
    chk("id after write", idv(coh, `SMC_NUM_GROUPS), rd);
  endtask

  task automatic t_alloc();
    wb(1'b1, `SMC_SCFG1_OFS, 32'h0000_0005, 1'b1);
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b0);
    chk("ns id", idv(coh, 8'h05), rd);
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b1);
    chk("s id", idv(coh, `SMC_NUM_GROUPS), rd);
    wb(1'b0, `SMC_SCFG1_OFS, 32'h0, 1'b1);
    chk("s alloc", 32'h0000_0005, rd);
    wb(1'b0, `SMC_SCFG1_OFS, 32'h0, 1'b0);
    chk("ns alloc hidden", `SMC_ZERO32, rd);
    wb(1'b1, `SMC_SCFG1_OFS, 32'h0000_0003, 1'b0);
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b0);
    chk("ns id kept", idv(coh, 8'h05), rd);
    wb(1'b0, 8'h08, 32'h0, 1'b1);
    chk("unmapped", 32'h0000_0000, rd);
  endtask

  task automatic t_clamp();
    wb(1'b1, `SMC_SCFG1_OFS, 32'h0000_00FF, 1'b1);
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b0);
    chk("ns id clamped", idv(coh, `SMC_NUM_GROUPS), rd);
    bsel <= 4'hE;
    wb(1'b1, `SMC_SCFG1_OFS, 32'h0000_0002, 1'b1);
    bsel <= 4'hF;
    wb(1'b0, `SMC_SCFG1_OFS, 32'h0, 1'b1);
    chk("lane 0 off", {24'h0, `SMC_NUM_GROUPS}, rd);
  endtask

  task automatic t_midreset();
    wb(1'b1, `SMC_SCFG1_OFS, 32'h0000_0007, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("dat mid reset", `SMC_ZERO32, dat);
    chk("ack mid reset", 32'h0, {31'h0, ack});
    wb(1'b0, `SMC_CAPID0_OFS, 32'h0, 1'b0);
    chk("ns id mid reset", idv(coh, `SMC_ALLOC_RESET), rd);
  endtask

  // ============================================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_wr_ignored();
    t_alloc();
    t_clamp();
    t_midreset();
    final_report();
  end

  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
